// *** logic/cxs_defines.svh ***
// constants for the instruction execution subset: encodings, widths, resets
// assumes inclusion by the execution unit and its bench only
`ifndef CXS_DEFINES_SVH
`define CXS_DEFINES_SVH
`define CXS_OP_NOP 4'h0
`define CXS_OP_BIT_CLEAR 4'h1
`define CXS_OP_BIT_SET 4'h2
`define CXS_OP_SKIP_SET 4'h3
`define CXS_OP_SKIP_CLEAR 4'h4
`define CXS_OP_REG_CLEAR 4'h5
`define CXS_OP_ACC_CLEAR 4'h6
`define CXS_OP_AND_LIT 4'h7
`define CXS_OP_COMPLEMENT 4'h8
`define CXS_OP_CALL 4'h9
`define CXS_OP_WDT_CLEAR 4'hA
`define CXS_PC_RESET 13'h0000
`define CXS_ACC_RESET 8'h00
`define CXS_ZERO_BYTE 8'h00
`define CXS_LATCH_LO 3
`define CXS_LATCH_HI 4
`define CXS_TARGET_HI 10
`endif

// *** logic/cxs_pkg.sv ***
// types shared by the instruction execution subset
// assumes cxs_defines.svh is compiled alongside
package cxs_pkg;
    // one decoded instruction from the fetch/decode stage
    typedef struct packed {
        logic valid;
        logic [3:0] op;
        logic [6:0] addr;
        logic [2:0] bit_sel;
        logic dest;
        logic [10:0] imm;
    } cxs_instr_t;

    // write toward the data register file
    typedef struct packed {
        logic we;
        logic [6:0] addr;
        logic [7:0] data;
    } cxs_reg_wr_t;

    // status flag update strobes and values
    typedef struct packed {
        logic z_we;
        logic z_val;
        logic wdt_flags_set;
    } cxs_flag_upd_t;

    typedef enum logic [0:0] {
        CXS_EXEC,
        CXS_FLUSH
    } cxs_phase_t;

    typedef struct packed {
        cxs_phase_t phase;
        logic [12:0] pc;
        logic [7:0] acc;
        logic z;
        cxs_reg_wr_t wr;
        cxs_flag_upd_t fl;
        logic push;
        logic [12:0] push_addr;
        logic wdt_clr;
        logic busy;
    } cxs_state_t;
endpackage

// *** logic/cxs_exec.sv ***
// execution unit for a subset of an 8-bit core's instruction set
// assumes one clk edge per instruction cycle, decoded instructions in,
// register file read data valid in the same cycle as the instruction
// Notes on behaviour
// - bit clear zeroes one bit, flags kept
// - bit set raises one bit, flags kept
// - literal AND into accumulator, zero flag only
// - skip-if-set flushes next when bit is one
// - skip-if-clear flushes next when bit zero
// - register clear writes zero, sets zero flag
// - accumulator clear writes zero, sets zero flag
// - call pushes program counter plus one first
// - call loads eleven-bit target, flags kept
// - call upper pc bits from latch 4:3
// - call takes two instruction cycles
// - watchdog clear resets counter and prescaler
// - watchdog clear sets expiry and sleep flags
// - complement inverts register, updates zero flag
// - destination bit picks accumulator or register
// - pc change or taken skip: no-op cycle
`timescale 1ns/1ns
`default_nettype none
`include "cxs_defines.svh"

module cxs_exec
    import cxs_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire cxs_instr_t instr,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] upper_latch,
    output cxs_reg_wr_t reg_wr,
    output cxs_flag_upd_t flag_upd,
    output logic [12:0] program_counter,
    output logic [7:0] accumulator,
    output logic zero_flag,
    output logic stack_push,
    output logic [12:0] stack_top,
    output logic watchdog_clear,
    output logic flush_cycle
);

    // ************************************************************
    // helpers
    // ************************************************************

    // zero test shared by the AND literal and complement paths; the clears set the flag directly
    function automatic logic is_zero(input logic [7:0] v);
        return v == `CXS_ZERO_BYTE;
    endfunction

    cxs_state_t s_q;
    cxs_state_t s_d;
    logic sel_bit;
    logic [7:0] one_hot;

    // ************************************************************
    // next state
    // ************************************************************

    // one decision per instruction cycle; a flush cycle ignores input
    always_comb begin
        s_d = s_q;
        s_d.wr.we = 1'b0;
        s_d.fl = '0;
        s_d.push = 1'b0;
        s_d.wdt_clr = 1'b0;
        s_d.busy = 1'b0;
        s_d.phase = CXS_EXEC;
        sel_bit = reg_rdata[instr.bit_sel];
        one_hot = 8'h01 << instr.bit_sel;
        case (s_q.phase)
            CXS_FLUSH: begin
                // second cycle runs as a no-op, pc already moved
                s_d.busy = 1'b1;
            end
            CXS_EXEC: begin
                if (instr.valid) begin
                    s_d.pc = s_q.pc + 13'h0001;
                    s_d.wr.addr = instr.addr;
                    case (instr.op)
                        `CXS_OP_BIT_CLEAR: begin
                            s_d.wr.we = 1'b1;
                            s_d.wr.data = reg_rdata & ~one_hot;
                        end
                        `CXS_OP_BIT_SET: begin
                            s_d.wr.we = 1'b1;
                            s_d.wr.data = reg_rdata | one_hot;
                        end
                        `CXS_OP_SKIP_SET: begin
                            if (sel_bit) begin
                                s_d.phase = CXS_FLUSH;
                                s_d.pc = s_q.pc + 13'h0002;
                            end
                        end
                        `CXS_OP_SKIP_CLEAR: begin
                            if (!sel_bit) begin
                                s_d.phase = CXS_FLUSH;
                                s_d.pc = s_q.pc + 13'h0002;
                            end
                        end
                        `CXS_OP_REG_CLEAR: begin
                            s_d.wr.we = 1'b1;
                            s_d.wr.data = `CXS_ZERO_BYTE;
                            s_d.z = 1'b1;
                            s_d.fl.z_we = 1'b1;
                            s_d.fl.z_val = 1'b1;
                        end
                        `CXS_OP_ACC_CLEAR: begin
                            s_d.acc = `CXS_ZERO_BYTE;
                            s_d.z = 1'b1;
                            s_d.fl.z_we = 1'b1;
                            s_d.fl.z_val = 1'b1;
                        end
                        `CXS_OP_AND_LIT: begin
                            s_d.acc = s_q.acc & instr.imm[7:0];
                            s_d.z = is_zero(s_q.acc & instr.imm[7:0]);
                            s_d.fl.z_we = 1'b1;
                            s_d.fl.z_val = s_d.z;
                        end
                        `CXS_OP_COMPLEMENT: begin
                            // destination 0 is accumulator, 1 the source
                            if (instr.dest) begin
                                s_d.wr.we = 1'b1;
                                s_d.wr.data = ~reg_rdata;
                            end else begin
                                s_d.acc = ~reg_rdata;
                            end
                            s_d.z = is_zero(~reg_rdata);
                            s_d.fl.z_we = 1'b1;
                            s_d.fl.z_val = s_d.z;
                        end
                        `CXS_OP_CALL: begin
                            // return address captured before pc changes
                            s_d.push = 1'b1;
                            s_d.push_addr = s_q.pc + 13'h0001;
                            s_d.pc = {upper_latch[`CXS_LATCH_HI:`CXS_LATCH_LO],
                                      instr.imm};
                            s_d.phase = CXS_FLUSH;
                        end
                        `CXS_OP_WDT_CLEAR: begin
                            s_d.wdt_clr = 1'b1;
                            s_d.fl.wdt_flags_set = 1'b1;
                        end
                        default: begin
                            // unknown codes behave as a no-op
                        end
                    endcase
                end
            end
            default: begin
                s_d.phase = CXS_EXEC;
            end
        endcase
    end

    // ************************************************************
    // state register
    // ************************************************************

    // synchronous reset; all outputs come from this one register
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.phase <= CXS_EXEC;
            s_q.pc <= `CXS_PC_RESET;
            s_q.acc <= `CXS_ACC_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_wr = s_q.wr;
    assign flag_upd = s_q.fl;
    assign program_counter = s_q.pc;
    assign accumulator = s_q.acc;
    assign zero_flag = s_q.z;
    assign stack_push = s_q.push;
    assign stack_top = s_q.push_addr;
    assign watchdog_clear = s_q.wdt_clr;
    assign flush_cycle = s_q.busy;

    // ************************************************************
    // checks
    // ************************************************************

    sequence call_issue_s;
        s_q.phase == CXS_EXEC && instr.valid && instr.op == `CXS_OP_CALL;
    endsequence

    sequence call_done_s;
        stack_push && stack_top == $past(program_counter) + 13'h0001;
    endsequence

    bit_clear_val_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_BIT_CLEAR |=> reg_wr.we &&
        !reg_wr.data[$past(instr.bit_sel)] && !flag_upd.z_we)
        else $error("bit clear wrong");
    bit_set_val_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_BIT_SET |=> reg_wr.we &&
        reg_wr.data == ($past(reg_rdata) | (8'h01 << $past(instr.bit_sel))))
        else $error("bit set wrong");
    and_lit_val_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_AND_LIT |=> accumulator ==
        ($past(accumulator) & $past(instr.imm[7:0])) &&
        zero_flag == (accumulator == 8'h00))
        else $error("and literal wrong");
    skip_set_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_SKIP_SET && reg_rdata[instr.bit_sel]
        |=> ##1 flush_cycle)
        else $error("skip if set missed");
    skip_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_SKIP_CLEAR && reg_rdata[instr.bit_sel]
        |=> ##1 !flush_cycle)
        else $error("skip if clear wrong");
    clear_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        (instr.op == `CXS_OP_REG_CLEAR || instr.op == `CXS_OP_ACC_CLEAR)
        |=> zero_flag && flag_upd.z_val)
        else $error("clear did not set zero");
    call_push_a: assert property (@(posedge clk) disable iff (!rstn)
        call_issue_s |=> call_done_s ##1 flush_cycle)
        else $error("call push wrong");
    call_target_a: assert property (@(posedge clk)
        disable iff (!rstn)
        call_issue_s |=> program_counter ==
        {$past(upper_latch[4:3]), $past(instr.imm)})
        else $error("call target wrong");
    wdt_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_WDT_CLEAR |=> watchdog_clear &&
        flag_upd.wdt_flags_set)
        else $error("watchdog clear wrong");
    comp_dest_a: assert property (@(posedge clk) disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_COMPLEMENT && !instr.dest
        |=> !reg_wr.we && accumulator == ~$past(reg_rdata))
        else $error("complement destination wrong");

    // a taken skip, in either polarity of the tested bit
    sequence skip_taken_s;
        s_q.phase == CXS_EXEC && instr.valid &&
        ((instr.op == `CXS_OP_SKIP_SET && reg_rdata[instr.bit_sel]) ||
        (instr.op == `CXS_OP_SKIP_CLEAR && !reg_rdata[instr.bit_sel]));
    endsequence

    // test cycle writes and pushes nothing, then the dropped slot runs as a no-op
    sequence drop_slot_s;
        !flush_cycle && !reg_wr.we && !stack_push ##1
        flush_cycle && !reg_wr.we && !flag_upd.z_we && !stack_push &&
        !watchdog_clear;
    endsequence

    clear_taken_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_SKIP_CLEAR && !reg_rdata[instr.bit_sel]
        |=> drop_slot_s)
        else $error("skip if clear not taken");
    skip_drop_a: assert property (@(posedge clk)
        disable iff (!rstn)
        skip_taken_s |=> drop_slot_s ##0
        (program_counter == $past(program_counter, 2) + 13'h0002))
        else $error("taken skip did not drop one slot");
    one_cycle_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op inside {`CXS_OP_NOP, `CXS_OP_BIT_CLEAR, `CXS_OP_BIT_SET,
        `CXS_OP_REG_CLEAR, `CXS_OP_ACC_CLEAR, `CXS_OP_AND_LIT,
        `CXS_OP_COMPLEMENT, `CXS_OP_WDT_CLEAR}
        |=> program_counter == $past(program_counter) + 13'h0001
        ##1 !flush_cycle)
        else $error("single cycle instruction stretched");
    acc_clear_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_ACC_CLEAR |=> accumulator == 8'h00 &&
        zero_flag && !reg_wr.we)
        else $error("accumulator clear wrong");
    call_flags_a: assert property (@(posedge clk)
        disable iff (!rstn)
        call_issue_s |=> program_counter[10:0] == $past(instr.imm) &&
        zero_flag == $past(zero_flag) && !flag_upd.z_we &&
        !flag_upd.wdt_flags_set)
        else $error("call touched flags or target");
    wdt_count_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_WDT_CLEAR |=> watchdog_clear && !reg_wr.we &&
        accumulator == $past(accumulator))
        else $error("watchdog clear pulse wrong");
    comp_reg_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_COMPLEMENT && instr.dest |=> reg_wr.we &&
        reg_wr.addr == $past(instr.addr) && reg_wr.data == ~$past(reg_rdata))
        else $error("complement to register wrong");
    comp_zero_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_COMPLEMENT |=> flag_upd.z_we &&
        zero_flag == (~$past(reg_rdata) == 8'h00))
        else $error("zero flag does not follow result");
    bit_keep_a: assert property (@(posedge clk)
        disable iff (!rstn)
        s_q.phase == CXS_EXEC && instr.valid &&
        instr.op == `CXS_OP_BIT_CLEAR |=> reg_wr.addr == $past(instr.addr) &&
        reg_wr.data == ($past(reg_rdata) & ~(8'h01 << $past(instr.bit_sel))))
        else $error("bit clear disturbed other bits");

endmodule

`default_nettype wire

// *** test/cxs_exec_bench.sv ***
// bench for the execution subset: a table of single instructions in a row,
// then a reset in mid-run and two calls written out by hand
// assumes cxs_pkg is compiled first and cxs_defines.svh is on the include path
`timescale 1ns/1ns
`default_nettype none
`include "cxs_defines.svh"

module cxs_exec_bench
    import cxs_pkg::*;
;
    typedef struct {
        cxs_instr_t i;
        logic [7:0] rd;
        cxs_reg_wr_t wr;
        logic [3:0] fz;
        logic [7:0] acc;
        logic z;
        logic fl;
    } cxs_row_t;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    cxs_instr_t instr = '0;
    logic [7:0] reg_rdata = 8'h00;
    logic [7:0] upper_latch = 8'h00;
    cxs_reg_wr_t reg_wr;
    cxs_flag_upd_t flag_upd;
    logic [12:0] program_counter;
    logic [12:0] stack_top;
    logic [7:0] accumulator;
    logic zero_flag;
    logic stack_push;
    logic watchdog_clear;
    logic flush_cycle;
    int n_fail = 0;
    int tests_run = 0;
    cxs_row_t rows[$];
    cxs_row_t e;
    logic pend = 1'b0;

    // ************************************************
    // clock and device
    // ************************************************
    always #2 clk = ~clk;

    cxs_exec DUT (.clk(clk), .rstn(rstn), .instr(instr),
        .reg_rdata(reg_rdata), .upper_latch(upper_latch), .reg_wr(reg_wr),
        .flag_upd(flag_upd), .program_counter(program_counter),
        .accumulator(accumulator), .zero_flag(zero_flag),
        .stack_push(stack_push), .stack_top(stack_top),
        .watchdog_clear(watchdog_clear), .flush_cycle(flush_cycle));

    // ************************************************
    // helpers
    // ************************************************
    function automatic cxs_instr_t mk(logic [3:0] op, logic [6:0] a,
        logic [2:0] b, logic d, logic [10:0] k);
        mk = '{1'b1, op, a, b, d, k};
    endfunction

    // fz packs z_we, z_val, expiry/sleep set, watchdog clear
    task automatic add(logic [3:0] op, logic [6:0] a, logic [2:0] b,
        logic d, logic [7:0] k, logic [7:0] rd, logic [15:0] wr,
        logic [3:0] fz, logic [7:0] acc, logic z, logic fl);
        rows.push_back('{mk(op, a, b, d, {3'h0, k}), rd, wr, fz, acc, z, fl});
    endtask

    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // results land one edge after the take; looking at the falling edge
    // keeps the compare clear of the launch edge of the next row
    always @(negedge clk) begin
        if (pend) begin
            chk("reg_wr", reg_wr.we ? 16'(reg_wr) : 16'h0000, e.wr);
            chk("flags", {flag_upd.z_we, flag_upd.z_val & flag_upd.z_we,
                flag_upd.wdt_flags_set, watchdog_clear}, e.fz);
            chk("acc_z", {accumulator, zero_flag}, {e.acc, e.z});
            chk("flush", {flush_cycle, stack_push}, {e.fl, 1'b0});
        end
    end

    // a hang ends the run through the same closing report
    initial begin
        #100000;
        n_fail++;
        $display("BAD timeout expected finish seen hang");
        test_done();
    end

    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        add(`CXS_OP_BIT_CLEAR, 7'h7F, 3'h7, 1'b0, 8'h00, 8'hFF,
            {1'b1, 7'h7F, 8'h7F}, 4'h0, 8'h00, 1'b0, 1'b0);
        add(`CXS_OP_BIT_SET, 7'h00, 3'h0, 1'b0, 8'h00, 8'h00,
            {1'b1, 7'h00, 8'h01}, 4'h0, 8'h00, 1'b0, 1'b0);
        add(`CXS_OP_BIT_SET, 7'h15, 3'h7, 1'b0, 8'h00, 8'h5A,
            {1'b1, 7'h15, 8'hDA}, 4'h0, 8'h00, 1'b0, 1'b0);
        add(`CXS_OP_COMPLEMENT, 7'h10, 3'h0, 1'b0, 8'h00, 8'h0F,
            16'h0000, 4'h8, 8'hF0, 1'b0, 1'b0);
        add(`CXS_OP_AND_LIT, 7'h00, 3'h0, 1'b0, 8'hFF, 8'h00,
            16'h0000, 4'h8, 8'hF0, 1'b0, 1'b0);
        add(`CXS_OP_AND_LIT, 7'h00, 3'h0, 1'b0, 8'h0F, 8'h00,
            16'h0000, 4'hC, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_COMPLEMENT, 7'h01, 3'h0, 1'b1, 8'h00, 8'h00,
            {1'b1, 7'h01, 8'hFF}, 4'h8, 8'h00, 1'b0, 1'b0);
        add(`CXS_OP_REG_CLEAR, 7'h7F, 3'h0, 1'b0, 8'h00, 8'hAA,
            {1'b1, 7'h7F, 8'h00}, 4'hC, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_COMPLEMENT, 7'h12, 3'h0, 1'b0, 8'h00, 8'h3C,
            16'h0000, 4'h8, 8'hC3, 1'b0, 1'b0);
        add(`CXS_OP_COMPLEMENT, 7'h11, 3'h0, 1'b1, 8'h00, 8'hFF,
            {1'b1, 7'h11, 8'h00}, 4'hC, 8'hC3, 1'b1, 1'b0);
        add(`CXS_OP_AND_LIT, 7'h00, 3'h0, 1'b0, 8'hFF, 8'h00,
            16'h0000, 4'h8, 8'hC3, 1'b0, 1'b0);
        add(`CXS_OP_ACC_CLEAR, 7'h00, 3'h0, 1'b0, 8'h00, 8'h00,
            16'h0000, 4'hC, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_SKIP_SET, 7'h05, 3'h3, 1'b0, 8'h00, 8'hF7,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_SKIP_CLEAR, 7'h05, 3'h3, 1'b0, 8'h00, 8'h08,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b0);
        // taken skips: the row after each one must come out as a no-op
        add(`CXS_OP_SKIP_SET, 7'h06, 3'h7, 1'b0, 8'h00, 8'h80,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_BIT_SET, 7'h00, 3'h1, 1'b0, 8'h00, 8'h00,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b1);
        add(`CXS_OP_SKIP_CLEAR, 7'h06, 3'h0, 1'b0, 8'h00, 8'hFE,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_COMPLEMENT, 7'h02, 3'h0, 1'b0, 8'h00, 8'h00,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b1);
        add(`CXS_OP_WDT_CLEAR, 7'h00, 3'h0, 1'b0, 8'h00, 8'h00,
            16'h0000, 4'h3, 8'h00, 1'b1, 1'b0);
        add(`CXS_OP_BIT_SET, 7'h40, 3'h4, 1'b0, 8'h00, 8'h00,
            {1'b1, 7'h40, 8'h10}, 4'h0, 8'h00, 1'b1, 1'b0);
        // a plain no-op with every field busy must change nothing
        add(`CXS_OP_NOP, 7'h7F, 3'h7, 1'b1, 8'hFF, 8'hFF,
            16'h0000, 4'h0, 8'h00, 1'b1, 1'b0);
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < rows.size(); k++) begin
            instr <= rows[k].i;
            reg_rdata <= rows[k].rd;
            @(posedge clk);
            e <= rows[k];
            pend <= 1'b1;
        end
        instr <= '0;
        @(posedge clk);
        pend <= 1'b0;
        // 17 single steps plus two taken skips of two; dropped slots hold
        @(negedge clk);
        chk("pc_count", program_counter, 13'h0015);
        $display("table of %0d rows done", rows.size());
        @(posedge clk);
        // reset in mid-run clears every output
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("reset", {program_counter, accumulator, zero_flag, stack_push,
            stack_top, watchdog_clear, flush_cycle, reg_wr, flag_upd}, 64'h0);
        $display("reset test done");
        // first call: latch bits 4:3 set, target all ones
        @(posedge clk);
        rstn <= 1'b1;
        instr <= mk(`CXS_OP_CALL, 7'h00, 3'h0, 1'b0, 11'h7FF);
        upper_latch <= 8'h18;
        @(posedge clk);
        instr <= mk(`CXS_OP_COMPLEMENT, 7'h03, 3'h0, 1'b0, 11'h000);
        upper_latch <= 8'hE7;
        @(negedge clk);
        chk("call1_pc", program_counter, 13'h1FFF);
        chk("call1_push", {stack_push, stack_top}, {1'b1, 13'h0001});
        chk("call1_flags", {flag_upd.z_we, flag_upd.wdt_flags_set,
            zero_flag, flush_cycle}, 4'h0);
        @(posedge clk);
        instr <= mk(`CXS_OP_CALL, 7'h7F, 3'h7, 1'b1, 11'h155);
        @(negedge clk);
        chk("call1_gap", {flush_cycle, stack_push, accumulator, reg_wr.we},
            {1'b1, 1'b0, 8'h00, 1'b0});
        // second call: return address wraps, latch bits 4:3 clear
        @(posedge clk);
        instr <= '0;
        @(negedge clk);
        chk("call2", {stack_push, stack_top, program_counter},
            {1'b1, 13'h0000, 13'h0155});
        $display("call sequence done");
        test_done();
    end
endmodule
`default_nettype wire
